/* hw/tpg_pkg.sv */
// package for the test pattern generator and checker
// assumes one 200 MHz-class user clock shared with both fifos
package tpg_pkg;

    localparam int unsigned WORD_W      = 256;
    localparam int unsigned DW_W        = 32;
    localparam int unsigned LANES       = 8;
    localparam int unsigned BLK_ADDR_W  = 48;
    localparam int unsigned REG_ADDR_W  = 8;
    localparam int unsigned WORDS_PER_BLK_LOG2 = 4;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_ADDR_LO  = 8'h04;
    localparam logic [7:0] OFS_ADDR_HI  = 8'h08;
    localparam logic [7:0] OFS_END      = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_COUNT    = 8'h14;
    localparam logic [7:0] OFS_EXP_BASE = 8'h40;
    localparam logic [7:0] OFS_OBS_BASE = 8'h60;

    // control register fields
    localparam int unsigned CTRL_WR_GO_BIT = 0;
    localparam int unsigned CTRL_RD_GO_BIT = 1;
    localparam int unsigned CTRL_SEL_LSB   = 4;

    // reset values
    localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;
    localparam logic [2:0]  RST_SEL    = 3'h0;

    typedef enum logic [2:0] {
        FILL_INC  = 3'b000,
        FILL_DEC  = 3'b001,
        FILL_ZERO = 3'b010,
        FILL_ONES = 3'b011,
        FILL_LFSR = 3'b100
    } tpg_fill_t;

    typedef enum logic [1:0] {
        MODE_IDLE  = 2'b00,
        MODE_WRITE = 2'b01,
        MODE_READ  = 2'b10
    } tpg_mode_t;

    typedef struct packed {
        logic [BLK_ADDR_W-1:0] start_block_addr;
        logic [31:0]           xfer_end_count;
        logic [2:0]            fill_select;
    } tpg_cmd_t;

endpackage

/* hw/tpg_gen_check.sv */
// test pattern generator and read checker with register port
// assumes write fifo with almost-full slack of at least one word
// and a first-word-fall-through read fifo on the same clock
`timescale 1ns/1ps

module tpg_gen_check import tpg_pkg::*; #(
    parameter int unsigned CNT_W = 32
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_reset,
    input  wire logic [REG_ADDR_W-1:0] i_reg_addr,
    input  wire logic [31:0]           i_reg_wdata,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    output logic      [31:0]           o_reg_rdata,
    input  wire logic                  i_wfifo_almost_full,
    output logic                       o_wfifo_push,
    output logic      [WORD_W-1:0]     o_wfifo_word_out,
    input  wire logic                  i_rfifo_empty,
    input  wire logic [WORD_W-1:0]     i_rfifo_word_in,
    output logic                       o_rfifo_pop,
    output logic                       o_write_xfer_active,
    output logic                       o_verify_mismatch
);

    // lfsr one step, taps 31, 21, 1
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1]};
    endfunction

    // increment dword for a lane
    function automatic logic [31:0] inc_dword(input logic [BLK_ADDR_W-1:0] blk,
                                              input logic [CNT_W-1:0]      cnt,
                                              input logic [2:0]            lane);
        inc_dword = {blk[24:0], cnt[WORDS_PER_BLK_LOG2-1:0], lane};
    endfunction

    tpg_mode_t             mode_r;
    tpg_mode_t             mode_nxt;
    tpg_cmd_t              cmd_r;
    logic [CNT_W-1:0]      xfer_word_counter_r;
    logic [CNT_W-1:0]      xfer_word_counter_nxt;
    logic [BLK_ADDR_W-1:0] block_addr_count_r;
    logic [BLK_ADDR_W-1:0] block_addr_count_nxt;
    logic [31:0]           set1_r;
    logic [31:0]           set2_r;
    logic [31:0]           set1_nxt;
    logic [31:0]           set2_nxt;
    logic                  wfifo_push_r;
    logic                  write_xfer_active_r;
    logic [WORD_W-1:0]     wfifo_word_out_r;
    logic                  verify_mismatch_r;
    logic [WORD_W-1:0]     exp_latch_r;
    logic [WORD_W-1:0]     obs_latch_r;
    logic [31:0]           reg_rdata_r;
    logic [31:0]           reg_rdata_nxt;

    // register decode
    wire logic ctrl_wr    = i_reg_wr && (i_reg_addr == OFS_CTRL);
    wire logic addr_lo_wr = i_reg_wr && (i_reg_addr == OFS_ADDR_LO);
    wire logic addr_hi_wr = i_reg_wr && (i_reg_addr == OFS_ADDR_HI);
    wire logic end_wr     = i_reg_wr && (i_reg_addr == OFS_END);
    wire logic write_pattern_go = ctrl_wr && i_reg_wdata[CTRL_WR_GO_BIT];
    wire logic read_pattern_go  = ctrl_wr && i_reg_wdata[CTRL_RD_GO_BIT] && !i_reg_wdata[CTRL_WR_GO_BIT];
    wire logic cmd_start        = write_pattern_go || read_pattern_go;

    wire logic at_end    = (xfer_word_counter_r == cmd_r.xfer_end_count);
    wire logic wr_issue  = (mode_r == MODE_WRITE) && !i_wfifo_almost_full && !at_end;
    wire logic rfifo_pop = (mode_r == MODE_READ) && !i_rfifo_empty && !at_end;
    wire logic xfer_fire = wr_issue || rfifo_pop;

    wire logic [WORDS_PER_BLK_LOG2-1:0] word_in_blk = xfer_word_counter_r[WORDS_PER_BLK_LOG2-1:0];
    wire logic blk_first = (word_in_blk == '0);
    wire logic blk_last  = xfer_fire && (word_in_blk == '1);

    wire logic [31:0] block_addr_value    = block_addr_count_r[31:0];
    wire logic [31:0] block_addr_inverted = ~block_addr_count_r[31:0];
    wire logic [31:0] seed1 = {block_addr_inverted[31:16], block_addr_value[15:0]};
    wire logic [31:0] seed2 = {block_addr_value[31:16], block_addr_inverted[15:0]};
    wire logic [31:0] set1_cur = blk_first ? seed1 : set1_r;
    wire logic [31:0] set2_cur = blk_first ? seed2 : set2_r;

    logic [31:0] even_fill_lanes [4];
    logic [31:0] odd_fill_lanes  [4];
    always_comb begin
        even_fill_lanes[0] = set1_cur;
        odd_fill_lanes[0]  = set2_cur;
        for (int i = 1; i < 4; i++) begin
            even_fill_lanes[i] = lfsr_step(even_fill_lanes[i-1]);
            odd_fill_lanes[i]  = lfsr_step(odd_fill_lanes[i-1]);
        end
        set1_nxt = lfsr_step(even_fill_lanes[3]);
        set2_nxt = lfsr_step(odd_fill_lanes[3]);
    end

    // pattern word
    logic [WORD_W-1:0] pattern_word;
    always_comb begin
        pattern_word = '0;
        for (int k = 0; k < LANES; k++) begin
            case (tpg_fill_t'(cmd_r.fill_select))
                FILL_INC:  pattern_word[k*DW_W +: DW_W] = inc_dword(block_addr_count_r, xfer_word_counter_r,
                                                                    3'(k));
                FILL_DEC:  pattern_word[k*DW_W +: DW_W] = ~inc_dword(block_addr_count_r, xfer_word_counter_r,
                                                                     3'(k));
                FILL_ZERO: pattern_word[k*DW_W +: DW_W] = 32'h0000_0000;
                FILL_ONES: pattern_word[k*DW_W +: DW_W] = 32'hFFFF_FFFF;
                FILL_LFSR: pattern_word[k*DW_W +: DW_W] = (k % 2 == 0) ? even_fill_lanes[k/2]
                                                                       : odd_fill_lanes[k/2];
                default:   pattern_word[k*DW_W +: DW_W] = 32'h0000_0000;
            endcase
        end
        // header in dwords 0 and 1
        if (blk_first) begin
            pattern_word[63:0] = 64'(block_addr_count_r);
        end
    end

    wire logic mismatch_now = rfifo_pop && (pattern_word != i_rfifo_word_in);

    // mode sequencing
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            MODE_IDLE: begin
                mode_nxt = MODE_IDLE;
            end
            MODE_WRITE: begin
                if (at_end || (wr_issue && (xfer_word_counter_nxt == cmd_r.xfer_end_count))) begin
                    mode_nxt = MODE_IDLE;
                end
            end
            MODE_READ: begin
                if (at_end) begin
                    mode_nxt = MODE_IDLE;
                end
            end
            default: begin
                mode_nxt = MODE_IDLE;
            end
        endcase
        if (write_pattern_go) begin
            mode_nxt = MODE_WRITE;
        end else if (read_pattern_go) begin
            mode_nxt = MODE_READ;
        end
    end

    // counters and block address
    always_comb begin
        xfer_word_counter_nxt = xfer_word_counter_r;
        block_addr_count_nxt  = block_addr_count_r;
        if (xfer_fire) begin
            xfer_word_counter_nxt = xfer_word_counter_r + CNT_W'(1);
        end
        if (blk_last) begin
            block_addr_count_nxt = block_addr_count_r + BLK_ADDR_W'(1);
        end
    end

    // read mux
    always_comb begin
        reg_rdata_nxt = RST_ZERO32;
        if (i_reg_addr == OFS_CTRL) begin
            reg_rdata_nxt = {25'h000_0000, cmd_r.fill_select, 4'h0};
        end else if (i_reg_addr == OFS_ADDR_LO) begin
            reg_rdata_nxt = cmd_r.start_block_addr[31:0];
        end else if (i_reg_addr == OFS_ADDR_HI) begin
            reg_rdata_nxt = {16'h0000, cmd_r.start_block_addr[47:32]};
        end else if (i_reg_addr == OFS_END) begin
            reg_rdata_nxt = cmd_r.xfer_end_count;
        end else if (i_reg_addr == OFS_STATUS) begin
            reg_rdata_nxt = {29'h0000_0000, verify_mismatch_r, mode_r == MODE_READ, mode_r == MODE_WRITE};
        end else if (i_reg_addr == OFS_COUNT) begin
            reg_rdata_nxt = 32'(xfer_word_counter_r);
        end else if (i_reg_addr[7:5] == OFS_EXP_BASE[7:5]) begin
            reg_rdata_nxt = exp_latch_r[i_reg_addr[4:2]*DW_W +: DW_W];
        end else if (i_reg_addr[7:5] == OFS_OBS_BASE[7:5]) begin
            reg_rdata_nxt = obs_latch_r[i_reg_addr[4:2]*DW_W +: DW_W];
        end
    end

    // software-written command fields
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cmd_r <= '{start_block_addr: '0, xfer_end_count: RST_ZERO32, fill_select: RST_SEL};
        end else begin
            if (addr_lo_wr) begin
                cmd_r.start_block_addr[31:0] <= i_reg_wdata;
            end
            if (addr_hi_wr) begin
                cmd_r.start_block_addr[47:32] <= i_reg_wdata[15:0];
            end
            if (end_wr) begin
                cmd_r.xfer_end_count <= i_reg_wdata;
            end
            if (ctrl_wr) begin
                cmd_r.fill_select <= i_reg_wdata[CTRL_SEL_LSB +: 3];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            mode_r <= MODE_IDLE;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // write active flag from its own flop
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            write_xfer_active_r <= 1'b0;
        end else begin
            write_xfer_active_r <= (mode_nxt == MODE_WRITE);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            xfer_word_counter_r <= '0;
            block_addr_count_r  <= '0;
        end else if (cmd_start) begin
            xfer_word_counter_r <= '0;
            block_addr_count_r  <= cmd_r.start_block_addr;
        end else begin
            xfer_word_counter_r <= xfer_word_counter_nxt;
            block_addr_count_r  <= block_addr_count_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset || cmd_start) begin
            set1_r <= RST_ZERO32;
            set2_r <= RST_ZERO32;
        end else if (xfer_fire) begin
            set1_r <= set1_nxt;
            set2_r <= set2_nxt;
        end
    end

    // write fifo strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wfifo_push_r <= 1'b0;
        end else begin
            wfifo_push_r <= wr_issue && !cmd_start;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wfifo_word_out_r <= '0;
        end else if (wr_issue) begin
            wfifo_word_out_r <= pattern_word;
        end
    end

    // checker flag and latches
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            verify_mismatch_r <= 1'b0;
            exp_latch_r       <= '0;
            obs_latch_r       <= '0;
        end else begin
            // mismatch sets flag, set beats clear
            if (mismatch_now) begin
                verify_mismatch_r <= 1'b1;
            end else if (cmd_start) begin
                verify_mismatch_r <= 1'b0;
            end
            if (mismatch_now && !verify_mismatch_r) begin
                exp_latch_r <= pattern_word;
                obs_latch_r <= i_rfifo_word_in;
            end
        end
    end

    // register read data
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            reg_rdata_r <= RST_ZERO32;
        end else if (i_reg_rd) begin
            reg_rdata_r <= reg_rdata_nxt;
        end else begin
            reg_rdata_r <= RST_ZERO32;
        end
    end

    assign o_reg_rdata         = reg_rdata_r;
    assign o_wfifo_push        = wfifo_push_r;
    assign o_wfifo_word_out    = wfifo_word_out_r;
    // pop must see empty in the same cycle
    assign o_rfifo_pop         = rfifo_pop;
    assign o_write_xfer_active = write_xfer_active_r;
    assign o_verify_mismatch   = verify_mismatch_r;

endmodule

/* sim/tpg_chk_asserts.sv */
// port assertions for the pattern generator
// bound onto every tpg_gen_check instance
`timescale 1ns/1ps
module tpg_chk import tpg_pkg::*; #(
    parameter int unsigned CNT_W = 32
) (
    input wire logic                  i_sys_clk,
    input wire logic                  i_reset,
    input wire logic [REG_ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0]           i_reg_wdata,
    input wire logic                  i_reg_wr,
    input wire logic                  i_reg_rd,
    input wire logic [31:0]           o_reg_rdata,
    input wire logic                  i_wfifo_almost_full,
    input wire logic                  o_wfifo_push,
    input wire logic                  i_rfifo_empty,
    input wire logic                  o_rfifo_pop,
    input wire logic                  o_write_xfer_active,
    input wire logic                  o_verify_mismatch
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    wire logic ctrl_wr = i_reg_wr && i_reg_addr == OFS_CTRL;
    wire logic st_rd   = i_reg_rd && i_reg_addr == OFS_STATUS;

    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        i_reset |=> !o_wfifo_push && !o_write_xfer_active && !o_verify_mismatch)
        else $error("reset left an output set");
    AST_GO_ACTIVE: assert property (
        ctrl_wr && i_reg_wdata[CTRL_WR_GO_BIT] |=> o_write_xfer_active)
        else $error("write go did not start a transfer");
    AST_ISSUE_PUSH: assert property (
        o_write_xfer_active && !i_wfifo_almost_full ##1 o_write_xfer_active |-> o_wfifo_push)
        else $error("ready fifo got no word");
    AST_FULL_PAUSE: assert property (
        i_wfifo_almost_full |=> !o_wfifo_push)
        else $error("push after almost full");
    AST_PUSH_IN_XFER: assert property (
        o_wfifo_push |-> $past(o_write_xfer_active))
        else $error("push outside a write transfer");
    AST_END_STOP: assert property (
        $fell(o_write_xfer_active) |=> !o_wfifo_push[*2])
        else $error("push after transfer end");
    AST_POP_EMPTY: assert property (
        o_rfifo_pop |-> !i_rfifo_empty && !o_write_xfer_active)
        else $error("pop from empty fifo");
    AST_STATUS_VIEW: assert property (
        st_rd |=> o_reg_rdata[0] == $past(o_write_xfer_active) && o_reg_rdata[2] == $past(o_verify_mismatch))
        else $error("status read disagrees with flags");
    AST_FAIL_STICKY: assert property (
        o_verify_mismatch && !ctrl_wr |=> o_verify_mismatch)
        else $error("mismatch flag dropped");
    AST_GO_CLEARS: assert property (
        ctrl_wr && i_reg_wdata[CTRL_RD_GO_BIT] && !o_rfifo_pop |=> !o_verify_mismatch)
        else $error("read go kept old mismatch");
endmodule

bind tpg_gen_check tpg_chk #(.CNT_W(CNT_W)) chk_u (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_wfifo_almost_full(i_wfifo_almost_full),
    .o_wfifo_push(o_wfifo_push), .i_rfifo_empty(i_rfifo_empty), .o_rfifo_pop(o_rfifo_pop),
    .o_write_xfer_active(o_write_xfer_active), .o_verify_mismatch(o_verify_mismatch));

/* sim/tpg_fifo_model.sv */
// behavioural write and read fifos on the far side
// one clock; pushed words come back as read data
`timescale 1ns/1ps
module tpg_fifo_model import tpg_pkg::*; (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    input  wire logic              i_push,
    input  wire logic [WORD_W-1:0] i_word,
    input  wire logic              i_pop,
    input  wire logic              i_stall,
    input  wire logic              i_corrupt,
    output logic                   o_almost_full,
    output logic                   o_empty,
    output logic      [WORD_W-1:0] o_word
);
    logic [WORD_W-1:0] mem_q [$];
    logic [WORD_W-1:0] head_r = '0;
    logic [WORD_W-1:0] last_r = '0;
    int                n_r    = 0;
    assign o_almost_full = i_stall;
    assign o_empty       = i_stall || n_r == 0;
    assign o_word = o_empty ? ~last_r : head_r ^ WORD_W'(i_corrupt);
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            mem_q.delete();
        end else begin
            if (i_pop && !o_empty) begin
                last_r <= o_word;
                void'(mem_q.pop_front());
            end
            if (i_push) begin
                mem_q.push_back(i_word);
            end
        end
        head_r <= mem_q.size() > 0 ? mem_q[0] : head_r;
        n_r    <= mem_q.size();
    end
endmodule

/* sim/testbench.sv */
// self-checking bench for the pattern generator
// write data loops back through the fifo model
`timescale 1ns/1ps
module testbench import tpg_pkg::*;;
    logic              clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, stall = 1'b0, bad = 1'b0;
    logic [7:0]        addr = 8'h00;
    logic [31:0]       wdata = 32'h0000_0000, rdata;
    logic              push, af, empty, pop, active, mism;
    logic [WORD_W-1:0] wword, rword;
    logic [47:0]       cur_blk;
    logic [2:0]        cur_sel;
    integer            seed = 32'hba6f7825;
    int                fail_count = 0, comparisons = 0, widx = 0, cycles = 0, pops = 0;

    tpg_gen_check #(.CNT_W(32)) dut_u (
        .i_sys_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_wfifo_almost_full(af),
        .o_wfifo_push(push), .o_wfifo_word_out(wword), .i_rfifo_empty(empty),
        .i_rfifo_word_in(rword), .o_rfifo_pop(pop), .o_write_xfer_active(active),
        .o_verify_mismatch(mism));
    tpg_fifo_model fifo_u (
        .i_sys_clk(clk), .i_reset(rst), .i_push(push), .i_word(wword), .i_pop(pop),
        .i_stall(stall), .i_corrupt(bad), .o_almost_full(af), .o_empty(empty), .o_word(rword));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] stp(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1]};
    endfunction

    function automatic logic [WORD_W-1:0] exp_word(input logic [47:0] b, input int w, input logic [2:0] sel);
        logic [31:0]       s [2];
        logic [31:0]       v;
        logic [WORD_W-1:0] r;
        s[0] = {~b[31:16], b[15:0]};
        s[1] = {b[31:16], ~b[15:0]};
        for (int k = 0; k < 4 * w; k++) s = '{stp(s[0]), stp(s[1])};
        for (int k = 0; k < 8; k++) begin
            v = {b[24:0], w[3:0], k[2:0]};
            case (sel)
                FILL_INC:  r[k*32+:32] = v;
                FILL_DEC:  r[k*32+:32] = ~v;
                FILL_ZERO: r[k*32+:32] = 32'h0000_0000;
                FILL_ONES: r[k*32+:32] = 32'hffff_ffff;
                default:   r[k*32+:32] = s[k%2];
            endcase
            if (k % 2 == 1) s = '{stp(s[0]), stp(s[1])};
        end
        if (w == 0) r[63:0] = {16'h0000, b};
        return r;
    endfunction

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic run_cmd(input logic [2:0] sel, input logic flip);
        logic [31:0] n, d;
        cur_blk = 48'({$random(seed), $random(seed)});
        n = 32'(17 + ($random(seed) & 15));
        cur_sel = sel;
        widx <= 0;
        pops <= 0;
        reg_wr(OFS_ADDR_LO, cur_blk[31:0]);
        reg_wr(OFS_ADDR_HI, {16'h0000, cur_blk[47:32]});
        reg_wr(OFS_END, n);
        reg_wr(OFS_CTRL, {25'h000_0000, sel, 4'h1});
        for (int k = 0; k < 3000 && (widx < n || active); k++) @(posedge clk);
        check(256'(widx), 256'(n));
        reg_rd(OFS_CTRL, d);
        check(256'(d[6:4]), 256'(sel));
        bad <= flip;
        reg_wr(OFS_CTRL, {25'h000_0000, sel, 4'h2});
        d = 32'h0000_0002;
        for (int k = 0; k < 300 && d[1]; k++) reg_rd(OFS_STATUS, d);
        check(256'(d[2]), 256'(flip));
        check(256'(mism), 256'(flip));
        check(256'(pops), 256'(n));
        reg_rd(OFS_COUNT, d);
        check(256'(d), 256'(n));
        if (flip) begin
            reg_rd(OFS_EXP_BASE, d);
            check(256'(d), 256'(cur_blk[31:0]));
            reg_rd(OFS_OBS_BASE, d);
            check(256'(d), 256'(cur_blk[31:0] ^ 32'h0000_0001));
        end
        bad <= 1'b0;
        $display("test sel=%0d flip=%0d done", sel, flip);
    endtask

    // random stalls, pushed-word check, timeout
    always @(posedge clk) begin
        stall  <= ($random(seed) & 3) == 0;
        cycles <= cycles + 1;
        if (!rst && push) begin
            check(wword, exp_word(cur_blk + 48'(widx / 16), widx % 16, cur_sel));
            widx <= widx + 1;
        end
        if (!rst && pop) begin
            pops <= pops + 1;
        end
        if (cycles == 60000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        logic [31:0] d;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        reg_rd(OFS_STATUS, d);
        check(256'(d), 256'(0));
        reg_rd(8'hf0, d);
        check(256'(d), 256'(0));
        for (int t = 0; t < 5; t++) run_cmd(3'(t), 1'b0);
        run_cmd(FILL_LFSR, 1'b1);
        run_cmd(FILL_INC, 1'b0);
        tally_and_finish();
    end
endmodule
